// File: pkg/ompc_pkg.sv
/*
  Shared constants for the on/off, margin and PWM configuration command
  block: command codes, operating-state values, register reset values,
  configuration bit positions and timing figures.
  Assumes a 10 MHz system clock shared by both ends of the link.
*/
package ompc_pkg;

  // System clock rate in hertz.
  localparam int CLK_HZ = 10_000_000;
  // Cycles per millisecond; the device takes this as its default.
  localparam int MS_CYCLES = CLK_HZ / 1000;

  // Command codes carried by the first byte of a frame.
  localparam logic [7:0] CMD_OP = 8'h01;
  localparam logic [7:0] CMD_FREQ = 8'h33;
  localparam logic [7:0] CMD_CHAN = 8'hd0;
  localparam logic [7:0] CMD_COMP = 8'hd3;
  localparam logic [7:0] CMD_MODE = 8'hd4;
  localparam logic [7:0] CMD_PHASE = 8'hf5;
  localparam logic [7:0] CMD_RESET = 8'hfd;

  // Operating-state values.
  localparam logic [7:0] OP_MARGIN_HI = 8'ha8;
  localparam logic [7:0] OP_MARGIN_LO = 8'h98;
  localparam logic [7:0] OP_ON = 8'h80;
  localparam logic [7:0] OP_SOFT_OFF = 8'h40;
  localparam logic [7:0] OP_IMM_OFF = 8'h00;

  // Register values after reset or reload.
  localparam logic [7:0] OP_RESET = 8'h80;
  localparam logic [15:0] FREQ_RESET = 16'hfbe8;
  localparam logic [7:0] CHAN_RESET = 8'h1d;
  localparam logic [7:0] COMP_RESET = 8'hae;
  localparam logic [7:0] MODE_RESET = 8'h02;
  localparam logic [7:0] PHASE_RESET = 8'h03;

  // Channel configuration bit positions.
  localparam int CHAN_VDR_BIT = 5;
  localparam int CHAN_NORUN_BIT = 4;
  localparam int CHAN_SHORT_BIT = 3;
  localparam int CHAN_TB_BIT = 2;
  // Bits the host keeps and sets in a channel configuration write.
  localparam logic [7:0] CHAN_KEEP_MASK = 8'h3c;
  localparam logic [7:0] CHAN_ONE_MASK = 8'h01;
  // On/off configuration bit that lets the operating state turn off.
  localparam int ONOFF_OP_BIT = 3;

  // Accepted switching frequency range in kilohertz.
  localparam int FREQ_MIN_KHZ = 250;
  localparam int FREQ_MAX_KHZ = 1000;

  // Extra run pin low time and short-cycle minimum off time, in ms.
  localparam int RUN_EXTRA_MS = 136;
  localparam int MIN_OFF_MS = 120;

  // Margin selection encoding.
  typedef enum logic [1:0] {
    OMPC_NOMINAL,
    OMPC_MARGIN_HI,
    OMPC_MARGIN_LO
  } ompc_margin_t;

endpackage

// File: pkg/ompc_link_if.sv
/*
  Link between the command host and the device: a host-made clock, a
  frame strobe and one open-drain data wire.
  Assumes the bench connects both modports; the wire level is resolved
  here from the two enables, with a pull-up when nobody drives low.
*/
`timescale 1ns/100ps
interface ompc_link_if;
  logic link_clk; // Bit clock made by the host.
  logic frame; // High for the length of one command frame.
  logic host_o; // Host data value, only 0 is ever driven.
  logic host_oe; // Host pulls the data wire.
  logic dev_o; // Device data value, only 0 is ever driven.
  logic dev_oe; // Device pulls the data wire.
  logic data; // Resolved wire level.

  // Open-drain resolution with pull-up.
  assign data = ~((host_oe & ~host_o) | (dev_oe & ~dev_o));

  modport host (output link_clk, output frame, output host_o,
    output host_oe, input data);
  modport device (input link_clk, input frame, input data,
    output dev_o, output dev_oe);
endinterface

// File: verilog/ompc_device.sv
/*
  Device end of the command link: receives framed commands, keeps the
  operating state, frequency and configuration registers, and runs the
  rail on/off sequencing with margin, reset and short-cycle handling.
  Assumes the analog loop reports ramp_busy and applies margin_sel and
  the ramps; timing inputs are in milliseconds.
*/
// Behaviour
// - Rail follows operating state and enable pin.
// - A8 high, 98 low, 80 always on.
// - 40 sequenced off, 00 immediate off.
// - Off values ignored unless on/off bit3.
// - Unsupported operating value: ignore, comm fault.
// - Margin changes ramp at transition rate.
// - State holds until command or pin.
// - Margin waits for running transition.
// - Faults stay active during margins.
// - Reset command: off, reload, clear, restart.
// - Frequency accepted from 250 to 1000.
// - Frequency is two-byte linear, default FBE8.
// - Only one sync clock master per line.
// - Free run when sync clock missing.
// - Frequency write with masters on: NACK, busy.
// - PLL unlocked until new frequency locks.
// - Channel bit5 selects shared pin role.
// - Bit4 clear: pulse run pin low off.
// - Bit3: early on aborts, 120ms off.
// - Bit2: timebase low disables output.
// - Reserved channel bits written 0, bit0 1.
// - Phase write with masters on: NACK, busy.
`timescale 1ns/100ps
module ompc_device import ompc_pkg::*; #(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  ompc_link_if.device link,
  input wire logic run_pin, // Enable pin, asynchronous.
  input wire logic timebase_line, // Sequencing timebase, asynchronous.
  input wire logic onoff_bit3, // On/off configuration bit 3.
  input wire logic other_master_on, // Second master channel running.
  input wire logic ramp_busy, // Output transition in progress.
  input wire logic fault_off, // Fault response demands output off.
  input wire logic eeprom_done, // Memory reload finished.
  input wire logic pll_locked, // Loop locked to the current frequency.
  input wire logic ext_clk_ok, // External sync clock present.
  input wire logic fault_clear, // Clears the sticky faults.
  input wire logic [15:0] turn_off_delay_ms,
  input wire logic [15:0] ramp_ms,
  input wire logic [15:0] restart_ms,
  output logic rail_on,
  output logic immediate_off,
  output logic [1:0] margin_sel,
  output logic ramp_start,
  output logic run_o,
  output logic run_oe,
  output logic temp_pin_is_vdr,
  output logic free_run,
  output logic pll_unlocked,
  output logic comm_logic_fault,
  output logic busy_fault,
  output logic eeprom_reload,
  output logic [7:0] operating_state,
  output logic [15:0] switching_frequency,
  output logic [7:0] channel_config,
  output logic [7:0] loop_compensation,
  output logic [7:0] pwm_mode_control,
  output logic [7:0] phase_arrangement_config
);

  // The millisecond divider needs at least two cycles per tick.
  if (MS_CYC < 2) begin : g_bad_ms
    $error("MS_CYC must be at least 2");
  end

  typedef enum {RS_OFF, RS_ON, RS_SEQ, RS_MINOFF} ompc_rail_t;

  // Three-stage synchronisers: link clock, frame, data, pin, timebase.
  logic [4:0] a_in, s1_q, s2_q, s3_q, st_q, stp_q;
  assign a_in = {timebase_line, run_pin, link.data, link.frame,
    link.link_clk};

  // A level counts only once stages two and three agree.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Idle pin levels, so that no false edge follows reset.
      s1_q <= 5'h14;
      s2_q <= 5'h14;
      s3_q <= 5'h14;
      st_q <= 5'h14;
      stp_q <= 5'h14;
    end else begin
      s1_q <= a_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= (s2_q & s3_q) | (st_q & (s2_q | s3_q));
      stp_q <= st_q;
    end
  end

  logic lk_rise, lk_fall, fr_rise, fr_fall, dat, en_pin, tb_low;
  assign lk_rise = st_q[0] & ~stp_q[0];
  assign lk_fall = ~st_q[0] & stp_q[0];
  assign fr_rise = st_q[1] & ~stp_q[1];
  assign fr_fall = ~st_q[1] & stp_q[1];
  assign dat = st_q[2];
  assign en_pin = st_q[3];
  assign tb_low = ~st_q[4];

  // Receiver state: bit and byte counters, shift register, payload.
  logic [3:0] bit_q;
  logic [1:0] nbyte_q;
  logic [7:0] sh_q, cmd_q;
  logic [15:0] dat_q;
  logic drop_q, ack_q, dev_oe_q;
  logic [7:0] byte_w;
  logic masters_on, known, busy_cmd;
  assign byte_w = {sh_q[6:0], dat};
  assign masters_on = rail_on | other_master_on;
  assign known = (byte_w == CMD_OP) || (byte_w == CMD_FREQ) ||
    (byte_w == CMD_CHAN) || (byte_w == CMD_COMP) ||
    (byte_w == CMD_MODE) || (byte_w == CMD_PHASE) ||
    (byte_w == CMD_RESET);
  assign busy_cmd = (byte_w == CMD_FREQ) || (byte_w == CMD_PHASE);

  // Shift bits in MSB first on link clock rises; decide the ack.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_q <= 4'h0;
      nbyte_q <= 2'h0;
      sh_q <= 8'h00;
      cmd_q <= 8'h00;
      dat_q <= 16'h0000;
      drop_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (fr_rise) begin
      bit_q <= 4'h0;
      nbyte_q <= 2'h0;
      drop_q <= 1'b0;
    end else if (st_q[1] && lk_rise) begin
      if (bit_q == 4'h8) begin
        bit_q <= 4'h0;
      end else begin
        sh_q <= byte_w;
        bit_q <= bit_q + 4'h1;
      end
      if (bit_q == 4'h7) begin
        if (nbyte_q != 2'h3) nbyte_q <= nbyte_q + 2'h1;
        if (nbyte_q == 2'h0) begin
          cmd_q <= byte_w;
          // Unknown or busy commands are refused at the command byte.
          if (!known || (busy_cmd && masters_on)) drop_q <= 1'b1;
          ack_q <= known && !(busy_cmd && masters_on);
        end else begin
          // Word data arrives low byte first.
          if (nbyte_q == 2'h1) dat_q[7:0] <= byte_w;
          if (nbyte_q == 2'h2) dat_q[15:8] <= byte_w;
          ack_q <= !drop_q;
        end
      end
    end
  end

  // Pull the data wire low through the ninth bit when acking.
  always_ff @(posedge clk) begin
    if (!rst_n || !st_q[1]) begin
      dev_oe_q <= 1'b0;
    end else if (lk_fall) begin
      dev_oe_q <= (bit_q == 4'h8) && ack_q;
    end
  end
  assign link.dev_oe = dev_oe_q;
  assign link.dev_o = 1'b0;

  // Frame end: check length and value, then execute.
  logic exec, len_ok, op_ok, op_skip, freq_ok;
  logic [4:0] f_exp;
  logic [31:0] f_mag, f_khz;
  assign exec = fr_fall && !drop_q;
  assign f_exp = dat_q[15:11];
  assign f_mag = {21'h00_0000, dat_q[10:0]};
  // Linear format: mantissa times two to the signed exponent.
  assign f_khz = dat_q[10] ? 32'h0000_0000 :
    (f_exp[4] ? (f_mag >> (~f_exp + 5'h1)) : (f_mag << f_exp));
  assign freq_ok = (f_khz >= 32'(FREQ_MIN_KHZ)) &&
    (f_khz <= 32'(FREQ_MAX_KHZ));
  always_comb begin
    if (cmd_q == CMD_RESET) len_ok = (nbyte_q == 2'h1);
    else if (cmd_q == CMD_FREQ) len_ok = (nbyte_q == 2'h3);
    else len_ok = (nbyte_q == 2'h2);
  end
  // Fault-ignoring margin values are simply not in the supported set.
  assign op_ok = (dat_q[7:0] == OP_MARGIN_HI) ||
    (dat_q[7:0] == OP_MARGIN_LO) || (dat_q[7:0] == OP_ON) ||
    (onoff_bit3 && (dat_q[7:0] == OP_SOFT_OFF ||
    dat_q[7:0] == OP_IMM_OFF));
  assign op_skip = !onoff_bit3 && (dat_q[7:0] == OP_SOFT_OFF ||
    dat_q[7:0] == OP_IMM_OFF);

  logic do_reset, op_wr;
  assign do_reset = exec && len_ok && cmd_q == CMD_RESET;
  assign op_wr = exec && len_ok && cmd_q == CMD_OP && op_ok;

  // Register writes; the reset command reloads every default.
  always_ff @(posedge clk) begin
    if (!rst_n || do_reset) begin
      operating_state <= OP_RESET;
      switching_frequency <= FREQ_RESET;
      channel_config <= CHAN_RESET;
      loop_compensation <= COMP_RESET;
      pwm_mode_control <= MODE_RESET;
      phase_arrangement_config <= PHASE_RESET;
    end else if (exec && len_ok) begin
      if (op_wr) operating_state <= dat_q[7:0];
      if (cmd_q == CMD_FREQ && freq_ok) switching_frequency <= dat_q;
      if (cmd_q == CMD_CHAN) channel_config <= dat_q[7:0];
      if (cmd_q == CMD_COMP) loop_compensation <= dat_q[7:0];
      if (cmd_q == CMD_MODE) pwm_mode_control <= dat_q[7:0];
      if (cmd_q == CMD_PHASE) phase_arrangement_config <= dat_q[7:0];
    end
  end

  // Sticky faults and PLL status; a new event wins over a clear.
  logic cml_set, busy_set;
  assign cml_set = exec && (!len_ok ||
    (cmd_q == CMD_OP && !op_ok && !op_skip) ||
    (cmd_q == CMD_FREQ && !freq_ok));
  assign busy_set = st_q[1] && lk_rise && bit_q == 4'h7 &&
    nbyte_q == 2'h0 && busy_cmd && masters_on;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      comm_logic_fault <= 1'b0;
      busy_fault <= 1'b0;
      pll_unlocked <= 1'b0;
      eeprom_reload <= 1'b0;
    end else begin
      comm_logic_fault <= cml_set ||
        (comm_logic_fault && !fault_clear && !do_reset);
      busy_fault <= busy_set ||
        (busy_fault && !fault_clear && !do_reset);
      if (exec && len_ok && cmd_q == CMD_FREQ && freq_ok) begin
        pll_unlocked <= 1'b1;
      end else if (pll_locked) begin
        pll_unlocked <= 1'b0;
      end
      if (do_reset) eeprom_reload <= 1'b1;
      else if (eeprom_done) eeprom_reload <= 1'b0;
    end
  end

  assign temp_pin_is_vdr = channel_config[CHAN_VDR_BIT];
  assign free_run = !ext_clk_ok;

  // Millisecond tick from the system clock.
  logic [31:0] ms_cnt_q;
  logic ms_tick;
  assign ms_tick = (ms_cnt_q == 32'(MS_CYC - 1));
  always_ff @(posedge clk) begin
    if (!rst_n || ms_tick) ms_cnt_q <= 32'h0000_0000;
    else ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
  end

  // Rail sequencing.
  ompc_rail_t rs_q;
  logic [17:0] tmr_q, run_tmr_q, seq_ms, run_ms;
  logic want_on, hard_off;
  assign seq_ms = {2'b00, turn_off_delay_ms} + {2'b00, ramp_ms};
  assign run_ms = (seq_ms + 18'(RUN_EXTRA_MS) > {2'b00, restart_ms}) ?
    seq_ms + 18'(RUN_EXTRA_MS) : {2'b00, restart_ms};
  assign want_on = en_pin && run_tmr_q == 18'h0_0000 && !eeprom_reload &&
    !(onoff_bit3 && operating_state[7] == 1'b0) &&
    !(channel_config[CHAN_TB_BIT] && tb_low) && !fault_off;
  assign hard_off = (onoff_bit3 && operating_state == OP_IMM_OFF) ||
    fault_off || (channel_config[CHAN_TB_BIT] && tb_low);

  // One state per phase of the on/off sequence.
  always_ff @(posedge clk) begin
    if (!rst_n || do_reset) begin
      rs_q <= RS_OFF;
      tmr_q <= 18'h0_0000;
      immediate_off <= 1'b0;
    end else begin
      immediate_off <= 1'b0;
      case (rs_q)
        RS_OFF: begin
          if (want_on) rs_q <= RS_ON;
        end
        RS_ON: begin
          if (!want_on && hard_off) begin
            rs_q <= RS_OFF;
            immediate_off <= 1'b1;
          end else if (!want_on) begin
            rs_q <= RS_SEQ;
            tmr_q <= seq_ms;
          end
        end
        RS_SEQ: begin
          if (want_on && channel_config[CHAN_SHORT_BIT]) begin
            rs_q <= RS_MINOFF;
            tmr_q <= 18'(MIN_OFF_MS);
            immediate_off <= 1'b1;
          end else if (want_on) begin
            rs_q <= RS_ON;
          end else if (hard_off || tmr_q == 18'h0_0000) begin
            rs_q <= RS_OFF;
            immediate_off <= hard_off;
          end else if (ms_tick) begin
            tmr_q <= tmr_q - 18'h0_0001;
          end
        end
        RS_MINOFF: begin
          if (tmr_q == 18'h0_0000) rs_q <= RS_OFF;
          else if (ms_tick) tmr_q <= tmr_q - 18'h0_0001;
        end
        default: rs_q <= RS_OFF;
      endcase
    end
  end
  assign rail_on = (rs_q == RS_ON) || (rs_q == RS_SEQ);

  // Run pin low pulse when the channel leaves the on state with channel bit 4 clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_tmr_q <= 18'h0_0000;
    end else if (rs_q == RS_ON && !want_on &&
      !channel_config[CHAN_NORUN_BIT]) begin
      run_tmr_q <= run_ms;
    end else if (ms_tick && run_tmr_q != 18'h0_0000) begin
      run_tmr_q <= run_tmr_q - 18'h0_0001;
    end
  end
  assign run_o = 1'b0;
  assign run_oe = run_tmr_q != 18'h0_0000;

  // Margin requests wait until no transition is running, then ramp.
  logic pend_q;
  logic [1:0] tgt_q;
  always_ff @(posedge clk) begin
    if (!rst_n || do_reset) begin
      pend_q <= 1'b0;
      tgt_q <= OMPC_NOMINAL;
      margin_sel <= OMPC_NOMINAL;
      ramp_start <= 1'b0;
    end else begin
      ramp_start <= 1'b0;
      if (op_wr && dat_q[7]) begin
        pend_q <= 1'b1;
        if (dat_q[7:0] == OP_MARGIN_HI) tgt_q <= OMPC_MARGIN_HI;
        else if (dat_q[7:0] == OP_MARGIN_LO) tgt_q <= OMPC_MARGIN_LO;
        else tgt_q <= OMPC_NOMINAL;
      end else if (pend_q && rs_q == RS_ON && !ramp_busy) begin
        pend_q <= 1'b0;
        margin_sel <= tgt_q;
        ramp_start <= tgt_q != margin_sel;
      end
    end
  end

endmodule // ompc_device

// File: verilog/ompc_host.sv
/*
  Host end of the command link: turns one user request into a frame with
  command byte and up to two data bytes, and reports the device's ack.
  Assumes the device acks in the ninth bit of each byte by pulling the
  data wire low; the host makes the link clock by dividing clk.
*/
`timescale 1ns/100ps
module ompc_host import ompc_pkg::*; #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  ompc_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_cmd,
  input wire logic [1:0] req_nbytes, // Data bytes: 0, 1 or 2.
  input wire logic [15:0] req_data, // Low byte is sent first.
  input wire logic masters_on, // Either master channel running.
  output logic done, // One-cycle pulse at the end of a request.
  output logic nacked // Last request refused or not acknowledged.
);

  // The device needs about five cycles to see a pin move; div_q is 8 bits.
  if (HALF < 6 || HALF > 256) begin : g_bad_half
    $error("HALF must lie between 6 and 256");
  end

  typedef enum {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL, H_GAP} ompc_hst_t;

  ompc_hst_t hs_q;
  logic [7:0] div_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q, last_q;
  logic [23:0] tx_q;
  logic [7:0] cur;
  logic half_end, refuse;
  logic [2:0] s_q;
  logic ack_st_q;

  assign req_ready = hs_q == H_IDLE;
  assign half_end = div_q == 8'(HALF - 1);
  assign cur = tx_q[8 * byte_q +: 8];
  // Frequency and phase writes are never sent while a master runs.
  assign refuse = masters_on &&
    (req_cmd == CMD_FREQ || req_cmd == CMD_PHASE);

  // Data wire synchroniser; the stable level is the ack value.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= 3'h7;
      ack_st_q <= 1'b1;
    end else begin
      s_q <= {s_q[1:0], link.data};
      if (s_q[1] == s_q[2]) ack_st_q <= s_q[2];
    end
  end

  // Half-period divider for the link clock.
  always_ff @(posedge clk) begin
    if (!rst_n || hs_q == H_IDLE || half_end) div_q <= 8'h00;
    else div_q <= div_q + 8'h01;
  end

  // Frame sequencer, one state per half period.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hs_q <= H_IDLE;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      last_q <= 2'h0;
      tx_q <= 24'h00_0000;
      done <= 1'b0;
      nacked <= 1'b0;
    end else begin
      done <= 1'b0;
      case (hs_q)
        H_IDLE: begin
          if (req_valid && refuse) begin
            done <= 1'b1;
            nacked <= 1'b1;
          end else if (req_valid) begin
            hs_q <= H_LEAD;
            nacked <= 1'b0;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            last_q <= req_nbytes;
            // Reserved channel bits are forced to their fixed values.
            if (req_cmd == CMD_CHAN) begin
              tx_q <= {8'h00, (req_data[7:0] & CHAN_KEEP_MASK) |
                CHAN_ONE_MASK, req_cmd};
            end else begin
              tx_q <= {req_data, req_cmd};
            end
          end
        end
        H_LEAD: if (half_end) hs_q <= H_LOW;
        H_LOW: if (half_end) hs_q <= H_HIGH;
        H_HIGH: begin
          if (half_end && bit_q != 4'h8) begin
            bit_q <= bit_q + 4'h1;
            hs_q <= H_LOW;
          end else if (half_end) begin
            bit_q <= 4'h0;
            if (ack_st_q || byte_q == last_q) begin
              nacked <= ack_st_q;
              hs_q <= H_TAIL;
            end else begin
              byte_q <= byte_q + 2'h1;
              hs_q <= H_LOW;
            end
          end
        end
        H_TAIL: if (half_end) hs_q <= H_GAP;
        H_GAP: begin
          if (half_end) begin
            hs_q <= H_IDLE;
            done <= 1'b1;
          end
        end
        default: hs_q <= H_IDLE;
      endcase
    end
  end

  // Pin drive: data changes only while the link clock is low.
  assign link.link_clk = hs_q == H_HIGH;
  assign link.frame = hs_q == H_LEAD || hs_q == H_LOW ||
    hs_q == H_HIGH || hs_q == H_TAIL;
  assign link.host_o = 1'b0;
  assign link.host_oe = (hs_q == H_LOW || hs_q == H_HIGH) &&
    bit_q != 4'h8 && !cur[3'(4'h7 - bit_q)];

endmodule // ompc_host

// File: sim/ompc_props.sv
/* Assertions on the command link and on the device outputs.
   Assumes one clock domain with a synchronous active-low reset. */
`timescale 1ns/100ps
module ompc_props import ompc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic frame,
  input wire logic rail_on,
  input wire logic [1:0] margin_sel,
  input wire logic ramp_start,
  input wire logic run_oe,
  input wire logic temp_pin_is_vdr,
  input wire logic [7:0] channel_config,
  input wire logic free_run,
  input wire logic ext_clk_ok,
  input wire logic ramp_busy,
  input wire logic fault_off,
  input wire logic other_master_on,
  input wire logic [7:0] operating_state,
  input wire logic [15:0] switching_frequency
);
  // One clock and one reset govern every check.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A margin selection that moves while the rail is up.
  sequence s_move;
    $changed(margin_sel) && rail_on;
  endsequence
  a_clk_idle_gap: assert property (!frame |-> !link_clk)
    else $error("link clock moves outside a frame");
  a_state_hold: assert property (
    $changed(operating_state) |-> !frame)
    else $error("operating state moved inside a frame");
  a_freq_idle_only: assert property (
    $changed(switching_frequency) |-> !$past(other_master_on))
    else $error("frequency changed with a master running");
  a_pin_role: assert property (
    temp_pin_is_vdr == channel_config[5])
    else $error("shared pin role differs from its bit");
  a_free_run: assert property (free_run == !ext_clk_ok)
    else $error("free run does not follow the sync clock");
  a_margin_wait: assert property (s_move |-> !$past(ramp_busy))
    else $error("margin moved during a transition");
  a_margin_ramp: assert property (
    $changed(margin_sel) |-> ##[0:1] ramp_start)
    else $error("margin moved without a ramp");
  a_fault_kept: assert property (fault_off |=> !rail_on)
    else $error("rail stayed on during a fault");
  a_run_pull: assert property (
    $rose(run_oe) |-> $past(rail_on) && !channel_config[4])
    else $error("run pin pulse without a commanded off");
endmodule // ompc_props

// File: sim/onoff_margin_pwm_config_tb.sv
/* Self-checking bench: host and device joined by the link interface.
   Assumes the package, interface, both ends and checker compile first. */
`timescale 1ns/100ps
module onoff_margin_pwm_config_tb import ompc_pkg::*; ;
  logic clk = 1'h0, rst_n = 1'h0;
  // Device stimulus; the millisecond timings stay at one.
  logic run_pin = 1'h0, timebase_line = 1'h1, onoff_bit3 = 1'h0;
  logic other_master_on = 1'h0, ramp_busy = 1'h0, fault_off = 1'h0;
  logic eeprom_done = 1'h1, pll_locked = 1'h1, ext_clk_ok = 1'h1;
  logic fault_clear = 1'h0;
  logic [15:0] turn_off_delay_ms = 16'h0001, ramp_ms = 16'h0001;
  logic [15:0] restart_ms = 16'h0001;
  logic rail_on, immediate_off, ramp_start, run_o, run_oe, free_run;
  logic temp_pin_is_vdr, pll_unlocked, comm_logic_fault, busy_fault;
  logic eeprom_reload, req_ready, done, nacked, masters_on;
  logic [1:0] margin_sel;
  logic [7:0] operating_state, channel_config, loop_compensation;
  logic [7:0] pwm_mode_control, phase_arrangement_config;
  logic [15:0] switching_frequency, v;
  logic req_valid = 1'h0;
  logic [7:0] req_cmd = 8'h00;
  logic [1:0] req_nbytes = 2'h0;
  logic [15:0] req_data = 16'h0000;
  int error_cnt = 0, samples_checked = 0, cyc = 0, seed = 32'h52c1, kh;
  int ks[4] = '{250, 1000, 1001, 249};
  logic [7:0] mv[2] = '{OP_MARGIN_LO, OP_MARGIN_HI};
  ompc_margin_t me[2] = '{OMPC_MARGIN_LO, OMPC_MARGIN_HI};
  ompc_link_if lk ();
  // Only this channel counts as a master seen by the host.
  assign masters_on = rail_on;
  ompc_device #(.MS_CYC(10)) i_ompc_device (.*, .link(lk.device));
  ompc_host i_ompc_host (.*, .link(lk.host));
  ompc_props i_ompc_props (.*, .link_clk(lk.link_clk), .frame(lk.frame));
  always #50 clk = ~clk;
  // Encodes kilohertz with a zero exponent.
  function automatic logic [15:0] f_l11(int k);
    return {5'h00, 11'(k)};
  endfunction
  function automatic bit f_ok(int k);
    return k >= FREQ_MIN_KHZ && k <= FREQ_MAX_KHZ;
  endfunction
  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(negedge clk);
  endtask
  // Hands one request to the host and waits for its done pulse.
  task automatic send(logic [7:0] c, logic [1:0] n, logic [15:0] d);
    int k;
    @(negedge clk);
    req_cmd = c;
    req_nbytes = n;
    req_data = d;
    req_valid = 1'h1;
    @(negedge clk);
    req_valid = 1'h0;
    for (k = 0; k < 2000 && done !== 1'h1; k++) @(negedge clk);
    chk("done", 16'h0001, 16'(done));
    wt(4);
  endtask
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    wt(5);
    rst_n = 1'h1;
    wt(10);
    chk("freq", FREQ_RESET, switching_frequency);
    chk("chan", 16'(CHAN_RESET), 16'(channel_config));
    run_pin = 1'h1;
    wt(20);
    chk("rail", 16'h0001, 16'(rail_on));
    send(CMD_OP, 2'h1, 16'(OP_SOFT_OFF));
    chk("rail", 16'h0001, 16'(rail_on));
    v = 16'($random(seed) & 32'h0000_007f) | 16'h0001;
    send(CMD_OP, 2'h1, v);
    chk("cml", 16'h0001, 16'(comm_logic_fault));
    chk("op", 16'(OP_ON), 16'(operating_state));
    send(CMD_COMP, 2'h1, 16'h0055);
    chk("comp", 16'h0055, 16'(loop_compensation));
    send(CMD_RESET, 2'h0, 16'h0000);
    wt(40);
    chk("cml", 16'h0000, 16'(comm_logic_fault));
    chk("rail", 16'h0001, 16'(rail_on));
    chk("comp", 16'(COMP_RESET), 16'(loop_compensation));
    send(CMD_FREQ, 2'h2, 16'h01f4);
    chk("nack", 16'h0001, 16'(nacked));
    onoff_bit3 = 1'h1;
    send(CMD_OP, 2'h1, 16'(OP_IMM_OFF));
    chk("rail", 16'h0000, 16'(rail_on));
    other_master_on = 1'h1;
    send(CMD_FREQ, 2'h2, 16'h01f4);
    chk("busy", 16'h0001, 16'(busy_fault));
    chk("nack", 16'h0001, 16'(nacked));
    send(CMD_PHASE, 2'h1, 16'h0002);
    chk("phase", 16'(PHASE_RESET), 16'(phase_arrangement_config));
    chk("nack", 16'h0001, 16'(nacked));
    other_master_on = 1'h0;
    v = FREQ_RESET;
    for (int i = 0; i < 8; i++) begin
      kh = i < 4 ? ks[i] : 240 + ($random(seed) & 32'h0000_03ff);
      ext_clk_ok = 1'($random(seed));
      fault_clear = 1'h1;
      pll_locked = 1'h1;
      wt(1);
      fault_clear = 1'h0;
      pll_locked = 1'h0;
      send(CMD_FREQ, 2'h2, f_l11(kh));
      if (f_ok(kh)) v = f_l11(kh);
      chk("pll", 16'(f_ok(kh)), 16'(pll_unlocked));
      chk("freq", v, switching_frequency);
      chk("cml", 16'(!f_ok(kh)), 16'(comm_logic_fault));
    end
    send(CMD_OP, 2'h1, 16'(OP_ON));
    wt(10);
    chk("rail", 16'h0001, 16'(rail_on));
    for (int i = 0; i < 2; i++) begin
      ramp_busy = (i == 0);
      send(CMD_OP, 2'h1, 16'(mv[i]));
      if (i == 0) chk("hold", 16'h0000, 16'(margin_sel));
      ramp_busy = 1'h0;
      wt(5);
      chk("margin", 16'(me[i]), 16'(margin_sel));
    end
    fault_off = 1'h1;
    wt(2);
    chk("rail", 16'h0000, 16'(rail_on));
    fault_off = 1'h0;
    timebase_line = 1'h0;
    wt(10);
    chk("rail", 16'h0000, 16'(rail_on));
    timebase_line = 1'h1;
    wt(10);
    send(CMD_CHAN, 2'h1, 16'h002d);
    chk("chan", 16'h002d, 16'(channel_config));
    chk("vdr", 16'h0001, 16'(temp_pin_is_vdr));
    send(CMD_OP, 2'h1, 16'(OP_SOFT_OFF));
    chk("rail", 16'h0001, 16'(rail_on));
    wt(40);
    chk("rail", 16'h0000, 16'(rail_on));
    chk("run_oe", 16'h0001, 16'(run_oe));
    test_done();
  end
endmodule // onoff_margin_pwm_config_tb
